// *** rtl/dbs_sram_port.sv ***
// Purpose: Device side of a burst-of-four double-data-rate common-I/O SRAM bus.
// Assumes: mclk far faster than the input clocks; every pin passes two flops first.
// Notes:   Beat edges are found by sampling the true and complementary clocks.

`timescale 1ns/1ps

module dbs_sram_port
#(
  parameter int BA_W   = 18,
  parameter int DW     = 18,
  parameter int MASK_W = 2
)
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              srst,
  // Input clock pair
  input  wire logic              k,
  input  wire logic              k_n,
  // Command pins
  input  wire logic              load_select_n,
  input  wire logic              read_write_sel,
  input  wire logic              dll_on,
  input  wire logic [BA_W-1:0]   burst_address,
  input  wire logic [MASK_W-1:0] byte_write_mask_n,
  // Common data bus
  input  wire logic [DW-1:0]     dq_in,
  output logic      [DW-1:0]     dq_out,
  output logic                   dq_oe,
  // Echo clocks and valid
  output logic                   echo_clock_true,
  output logic                   echo_clock_complement,
  output logic                   read_data_valid,
  // Status
  output logic                   write_overflow
);

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int AW   = BA_W + dbs_pkg::BEAT_W;
  localparam int LANE = DW / MASK_W;
  localparam int FW   = AW + MASK_W + DW;
  localparam int SW   = 5 + BA_W + MASK_W + DW;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [SW-1:0]          pin_s;
  logic                   k_s;
  logic                   kn_s;
  logic                   ld_n_s;
  logic                   rw_s;
  logic                   dll_s;
  logic [BA_W-1:0]        addr_s;
  logic [MASK_W-1:0]      mask_s;
  logic [DW-1:0]          data_s;
  logic                   k_d;
  logic                   kn_d;
  logic [2:0]             arm;
  logic                   k_rise;
  logic                   kn_rise;
  logic                   half_edge;
  logic                   cmd_take;
  logic                   rd_cmd;
  logic                   wr_cmd;
  dbs_pkg::dbs_cnt_t      lat;

  logic                   rs_v    [dbs_pkg::SLOTS];
  dbs_pkg::dbs_cnt_t      rs_cnt  [dbs_pkg::SLOTS];
  logic [BA_W-1:0]        rs_addr [dbs_pkg::SLOTS];
  logic                   rs_sel;
  logic                   ws_v    [dbs_pkg::SLOTS];
  dbs_pkg::dbs_cnt_t      ws_cnt  [dbs_pkg::SLOTS];
  logic [BA_W-1:0]        ws_addr [dbs_pkg::SLOTS];
  logic                   ws_sel;

  logic                   rd_start;
  logic [BA_W-1:0]        start_addr;
  logic                   rd_active;
  dbs_pkg::dbs_beat_t     rd_beat;
  logic [BA_W-1:0]        rd_base;
  logic                   rd_launch;
  dbs_pkg::dbs_beat_t     rd_idx;
  logic [AW-1:0]          rd_word;

  logic                   wr_take;
  dbs_pkg::dbs_beat_t     wr_idx;
  logic [BA_W-1:0]        wr_base;

  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  logic [FW-1:0]          fifo_out;
  logic [AW-1:0]          drain_addr;
  logic [MASK_W-1:0]      drain_mask_n;
  logic [DW-1:0]          drain_data;
  logic [DW-1:0]          array [0:(2**AW)-1];

  // ****************************************************************
  // Pin sampling and clock edge detection
  // ****************************************************************
  dbs_sync #(.W(SW)) u_sync
  (
    .mclk (mclk),
    .srst (srst),
    .d    ({k, k_n, load_select_n, read_write_sel, dll_on, burst_address, byte_write_mask_n, dq_in}),
    .q    (pin_s)
  );

  // All pins share one sync depth so data stays aligned with its clock edge
  assign {k_s, kn_s, ld_n_s, rw_s, dll_s, addr_s, mask_s, data_s} = pin_s;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      k_d  <= dbs_pkg::RST_BIT;
      kn_d <= dbs_pkg::RST_BIT;
      arm  <= '0;
    end
    else
    begin
      k_d  <= k_s;
      kn_d <= kn_s;
      arm  <= {arm[1:0], 1'b1};
    end
  end

  // Sync stages restart at zero, so a pin idling high would fake a rise; arm waits them out
  assign k_rise    = k_s & ~k_d & arm[2];
  // Half-edges alternate only while the pair stays in antiphase
  assign kn_rise   = kn_s & ~kn_d & arm[2];
  assign half_edge = k_rise | kn_rise;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  assign cmd_take = k_rise & ~ld_n_s;
  assign rd_cmd   = cmd_take & rw_s;
  assign wr_cmd   = cmd_take & ~rw_s;
  assign lat      = dll_s ? dbs_pkg::RD_LAT_HALF : dbs_pkg::RD_LAT_HALF_DLL_OFF;

  // ****************************************************************
  // Read slots: two, since a new read may come before the last one starts
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < dbs_pkg::SLOTS; i++)
      begin
        rs_v[i]    <= dbs_pkg::RST_BIT;
        rs_cnt[i]  <= dbs_pkg::RST_CNT;
        rs_addr[i] <= '0;
      end
      rs_sel <= dbs_pkg::RST_BIT;
    end
    else
    begin
      for (int i = 0; i < dbs_pkg::SLOTS; i++)
      begin
        if (half_edge && rs_v[i])
        begin
          if (rs_cnt[i] == lat - 3'h1)
            rs_v[i] <= 1'b0;
          else
            rs_cnt[i] <= rs_cnt[i] + 3'h1;
        end
      end
      // Slots alternate; commands at most every other cycle keep them apart
      if (rd_cmd)
      begin
        rs_v[rs_sel]    <= 1'b1;
        rs_cnt[rs_sel]  <= dbs_pkg::RST_CNT;
        rs_addr[rs_sel] <= addr_s;
        rs_sel          <= ~rs_sel;
      end
    end
  end

  always_comb
  begin
    rd_start   = 1'b0;
    start_addr = rs_addr[0];
    for (int i = 0; i < dbs_pkg::SLOTS; i++)
    begin
      if (half_edge && rs_v[i] && rs_cnt[i] == lat - 3'h1)
      begin
        rd_start   = 1'b1;
        start_addr = rs_addr[i];
      end
    end
  end

  // ****************************************************************
  // Read burst engine
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rd_active <= dbs_pkg::RST_BIT;
      rd_beat   <= '0;
      rd_base   <= '0;
    end
    else if (rd_start)
    begin
      rd_active <= 1'b1;
      rd_beat   <= '0;
      rd_base   <= start_addr;
    end
    else if (half_edge && rd_active)
    begin
      if (rd_beat == dbs_pkg::LAST_BEAT)
        rd_active <= 1'b0;
      else
        rd_beat <= rd_beat + 2'h1;
    end
  end

  assign rd_launch = rd_start | (half_edge & rd_active & (rd_beat != dbs_pkg::LAST_BEAT));
  assign rd_idx    = rd_start ? 2'h0 : rd_beat + 2'h1;
  assign rd_word   = {(rd_start ? start_addr : rd_base), rd_idx};

  // Drives the bus only across the four beats, then releases at the next half-edge
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      dq_out          <= '0;
      dq_oe           <= dbs_pkg::RST_BIT;
      read_data_valid <= dbs_pkg::RST_BIT;
    end
    else if (rd_launch)
    begin
      dq_out          <= array[rd_word];
      dq_oe           <= 1'b1;
      read_data_valid <= 1'b1;
    end
    else if (half_edge && rd_active && rd_beat == dbs_pkg::LAST_BEAT)
    begin
      dq_oe           <= 1'b0;
      read_data_valid <= 1'b0;
    end
  end

  // Echo pair registered on the same edge as data, so transitions coincide
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      echo_clock_true       <= dbs_pkg::RST_BIT;
      echo_clock_complement <= dbs_pkg::RST_BIT;
    end
    else
    begin
      echo_clock_true       <= k_s;
      echo_clock_complement <= kn_s;
    end
  end

  // ****************************************************************
  // Write slots and late beat capture
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < dbs_pkg::SLOTS; i++)
      begin
        ws_v[i]    <= dbs_pkg::RST_BIT;
        ws_cnt[i]  <= dbs_pkg::RST_CNT;
        ws_addr[i] <= '0;
      end
      ws_sel <= dbs_pkg::RST_BIT;
    end
    else
    begin
      for (int i = 0; i < dbs_pkg::SLOTS; i++)
      begin
        if (half_edge && ws_v[i])
        begin
          if (ws_cnt[i] == dbs_pkg::WR_LAST_HALF - 3'h1)
            ws_v[i] <= 1'b0;
          else
            ws_cnt[i] <= ws_cnt[i] + 3'h1;
        end
      end
      if (wr_cmd)
      begin
        ws_v[ws_sel]    <= 1'b1;
        ws_cnt[ws_sel]  <= dbs_pkg::RST_CNT;
        ws_addr[ws_sel] <= addr_s;
        ws_sel          <= ~ws_sel;
      end
    end
  end

  // Beat one waits one full cycle after the command
  always_comb
  begin
    wr_take = 1'b0;
    wr_idx  = 2'h0;
    wr_base = ws_addr[0];
    for (int i = 0; i < dbs_pkg::SLOTS; i++)
    begin
      if (half_edge && ws_v[i] && ws_cnt[i] >= dbs_pkg::WR_FIRST_HALF - 3'h1)
      begin
        wr_take = 1'b1;
        wr_idx  = dbs_pkg::BEAT_W'(ws_cnt[i] - (dbs_pkg::WR_FIRST_HALF - 3'h1));
        wr_base = ws_addr[i];
      end
    end
  end

  // Sticky: a beat that finds the buffer full is lost, so software must know
  always_ff @(posedge mclk)
  begin
    if (srst)
      write_overflow <= dbs_pkg::RST_BIT;
    else if (wr_take && !fifo_in_ready)
      write_overflow <= 1'b1;
  end

  // ****************************************************************
  // Write buffer and array
  // ****************************************************************
  dbs_fifo #(.W(FW), .DEPTH(dbs_pkg::FIFO_DEPTH)) u_fifo
  (
    .mclk      (mclk),
    .srst      (srst),
    .in_valid  (wr_take),
    .in_ready  (fifo_in_ready),
    .in_data   ({wr_base, wr_idx, mask_s, data_s}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  assign {drain_addr, drain_mask_n, drain_data} = fifo_out;
  // Array has one port; a read launch stalls the drain for that cycle
  assign fifo_out_ready = ~rd_launch;

  // Buffer empties in a few mclk, long before any later read launches
  always_ff @(posedge mclk)
  begin
    if (fifo_out_valid && fifo_out_ready)
    begin
      for (int l = 0; l < MASK_W; l++)
      begin
        if (!drain_mask_n[l])
          array[drain_addr][l*LANE +: LANE] <= drain_data[l*LANE +: LANE];
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [3:0] rd_since;

  always_ff @(posedge mclk)
  begin
    if (srst)
      rd_since <= 4'h0;
    else if (rd_cmd)
      rd_since <= 4'h0;
    else if (half_edge && rd_since != 4'hf)
      rd_since <= rd_since + 4'h1;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_burst_four_beats: assert property ($fell(rd_active) |-> $past(rd_beat) == 2'h3)
    else $error("read burst ended at a beat other than the fourth");
  a_read_latency_half: assert property (rd_start |-> (rd_since == {1'b0, lat} - 4'h1)
                                        || (rd_since + 4'h4 == {1'b0, lat} - 4'h1))
    else $error("read burst started at the wrong half-edge");
  a_cmd_true_rise: assert property ((rs_v[0] && !$past(rs_v[0])) || (ws_v[0] && !$past(ws_v[0]))
                                    |-> $past(k_rise))
    else $error("operation began off a true-clock rising edge");
  a_bus_release: assert property (dq_oe |-> rd_active && read_data_valid)
    else $error("data bus driven outside a read burst");
  a_write_beat_edge: assert property (wr_take |-> (wr_idx[0] ? kn_rise : k_rise))
    else $error("write beat captured on the wrong clock");
  a_read_beat_edge: assert property (rd_launch |-> (rd_idx[0] ? k_rise : kn_rise))
    else $error("read beat launched on the wrong clock");
  a_write_drain_time: assert property (wr_take && wr_idx == 2'h3 |-> ##[1:8] !fifo_out_valid)
    else $error("buffered write not completed in time");
  a_echo_valid_align: assert property ($changed(read_data_valid)
                                       |-> $changed(echo_clock_true) || $changed(echo_clock_complement))
    else $error("valid changed away from an echo clock edge");
  a_coherent_read: assert property (rd_launch |-> !fifo_out_valid)
    else $error("read launched while writes still buffered");

  c_read_burst: cover property (rd_start);
  c_write_burst: cover property (wr_take && wr_idx == 2'h3);
  c_dll_off_read: cover property (rd_start && !dll_s);
  c_back_to_back: cover property (rd_start && rd_active);

endmodule

// *** rtl/dbs_pkg.sv ***
// Purpose: Shared constants for the burst-of-four common-I/O SRAM port model.
// Assumes: Half-edge counts are rising edges of the true and complementary input clocks.
// Notes:   Half-edge 0 is the true-clock rising edge that carries the command.

package dbs_pkg;

  // ****************************************************************
  // Burst shape
  // ****************************************************************
  localparam int BEATS   = 4;
  localparam int BEAT_W  = 2;
  localparam int SLOTS   = 2;
  localparam int CNT_W   = 3;

  typedef logic [CNT_W-1:0]  dbs_cnt_t;
  typedef logic [BEAT_W-1:0] dbs_beat_t;

  localparam dbs_beat_t LAST_BEAT = 2'h3;

  // ****************************************************************
  // Timing in half-edges after the command edge
  // ****************************************************************
  // Loop active: first read beat on the third complementary edge
  localparam dbs_cnt_t RD_LAT_HALF         = 3'h5;
  // Loop bypassed: 1.5-cycle latency, first beat on the second complementary edge
  localparam dbs_cnt_t RD_LAT_HALF_DLL_OFF = 3'h3;
  // Late write: beat one on the next true edge, beat four three halves later
  localparam dbs_cnt_t WR_FIRST_HALF       = 3'h2;
  localparam dbs_cnt_t WR_LAST_HALF        = 3'h5;

  // ****************************************************************
  // Write buffer
  // ****************************************************************
  localparam int FIFO_DEPTH  = 8;
  localparam int DRAIN_LIMIT = 8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic     RST_BIT = 1'b0;
  localparam dbs_cnt_t RST_CNT = 3'h0;

endpackage

// *** rtl/dbs_sync.sv ***
// Purpose: Two-flop synchroniser bank for pins sampled by mclk.
// Assumes: Bits of the bank are independent levels.
// Notes:   Stage one is read only by stage two.

`timescale 1ns/1ps

module dbs_sync
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         srst,
  // Pins in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// *** rtl/dbs_fifo.sv ***
// Purpose: Write-beat buffer between beat capture and the storage array.
// Assumes: DEPTH is a power of two.
// Notes:   Valid/ready on both sides; full and empty are exact.

`timescale 1ns/1ps

module dbs_fifo
#(
  parameter int W     = 8,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         srst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  store [0:DEPTH-1];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  logic          push;
  logic          pop;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge mclk)
  begin
    if (push)
      store[wr_ptr] <= in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + PW'(1);
      if (pop)
        rd_ptr <= rd_ptr + PW'(1);
      if (push && !pop)
        count <= count + (PW+1)'(1);
      else if (pop && !push)
        count <= count - (PW+1)'(1);
    end
  end

endmodule

// *** sim/dbs_ctrl_model.sv ***
// Purpose: Memory controller model for the common-I/O burst bus.
// Assumes: Input clock pair of 125 ns, unrelated to mclk.
// Notes:   Released lines show the inverse of their last value.

`timescale 1ns/1ps

module dbs_ctrl_model
(
  // Clock pair and command
  output logic             k,
  output logic             k_n,
  output logic             load_select_n,
  output logic             read_write_sel,
  output logic [5:0]       burst_address,
  // Write beats and the shared bus
  output logic [1:0]       byte_write_mask_n,
  output logic [17:0]      dq_in,
  input  wire logic [17:0] dq_out,
  input  wire logic        dq_oe
);
  logic [17:0] wdata;
  logic [17:0] idle_q;
  logic        drv;
  real         cmd_t;
  event        cmd_ev;

  // ********************
  // Clock and bus
  // ********************
  assign k_n = ~k;
  // A released bus must never look like the data last seen on it
  assign dq_in = dq_oe ? dq_out : (drv ? wdata : idle_q);

  initial
  begin
    load_select_n = 1'b1;
    read_write_sel = 1'b0;
    burst_address = 6'h00;
    byte_write_mask_n = 2'h3;
    idle_q = 18'h2a5a5;
    drv = 1'b0;
    k = 1'b0;
    forever
    begin
      #62.5;
      k = ~k;
    end
  end

  always @(negedge dq_oe)
    idle_q = ~dq_out;

  // ********************
  // Transfers
  // ********************
  // Pins move just after k_n rises, so they stand still around the k edge
  task automatic command(input logic rd, input logic [5:0] a);
    @(posedge k_n);
    #1;
    load_select_n = 1'b0;
    read_write_sel = rd;
    burst_address = a;
    @(posedge k);
    cmd_t = $realtime;
    -> cmd_ev;
    @(posedge k_n);
    #1;
    load_select_n = 1'b1;
    read_write_sel = ~rd;
    burst_address = ~a;
  endtask

  // Beat i is d[18*i +: 18] with mask m[2*i +: 2], centred on its half-edge
  task automatic write(input logic [5:0] a, input logic [71:0] d, input logic [7:0] m);
    command(1'b0, a);
    #30.25;
    drv = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wdata = d[18*i +: 18];
      byte_write_mask_n = m[2*i +: 2];
      #62.5;
    end
    drv = 1'b0;
    idle_q = ~wdata;
    byte_write_mask_n = ~byte_write_mask_n;
  endtask
endmodule

// *** sim/tb_dbs_sram_port.sv ***
// Purpose: Self-checking bench for the burst-of-four common-I/O SRAM port.
// Assumes: The controller model owns the input clock pair and the write beats.
// Notes:   Read beats are sampled 40 ns after their pin edge, inside the stand time.

`timescale 1ns/1ps

module tb_dbs_sram_port;
  localparam logic [71:0] WA = {18'h3c0f1, 18'h2d2d2, 18'h1e1e3, 18'h0f0f4};
  localparam logic [71:0] WN = ~WA;
  // Beat 0 lane 0, beat 1 lane 1 and all of beat 3 take the new data
  localparam logic [71:0] WM = {WN[71:54], WA[53:36], WN[35:27], WA[26:9], WN[8:0]};
  localparam logic [71:0] WC = {18'h12345, 18'h23456, 18'h34567, 18'h0abcd};
  localparam real         LAT2 = 312.5;
  localparam real         LAT1 = 187.5;

  logic        mclk, srst, dll_on, k, k_n, load_select_n, read_write_sel, dq_oe;
  logic        echo_clock_true, echo_clock_complement, read_data_valid, write_overflow;
  logic [5:0]  burst_address;
  logic [1:0]  byte_write_mask_n;
  logic [17:0] dq_in, dq_out;
  int          fails, comparisons, cycles;

  // ********************
  // Harness
  // ********************
  dbs_sram_port #(.BA_W(6), .DW(18), .MASK_W(2)) dbs_sram_port_i
  (
    .mclk(mclk), .srst(srst), .k(k), .k_n(k_n), .load_select_n(load_select_n),
    .read_write_sel(read_write_sel), .dll_on(dll_on), .burst_address(burst_address),
    .byte_write_mask_n(byte_write_mask_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .echo_clock_true(echo_clock_true), .echo_clock_complement(echo_clock_complement),
    .read_data_valid(read_data_valid), .write_overflow(write_overflow)
  );

  dbs_ctrl_model dbs_ctrl_model_i
  (
    .k(k), .k_n(k_n), .load_select_n(load_select_n), .read_write_sel(read_write_sel),
    .burst_address(burst_address), .byte_write_mask_n(byte_write_mask_n), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe)
  );

  initial
  begin
    mclk = 1'b0;
    forever
    begin
      #2.5;
      mclk = ~mclk;
    end
  end

  // The run needs about 1500 cycles; the ceiling leaves ample margin
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      $display("Error at %0t: run timed out", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [17:0] got, input logic [17:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Times are from the command's k edge; post is the state after the last beat
  task automatic check_read(input real t0, input real lat, input logic [71:0] exp, input logic post);
    // Early look kept 10 ns ahead of the latency edge, before valid can rise
    if (t0 + lat - 10.0 > $realtime)
    begin
      #(t0 + lat - 10.0 - $realtime);
      chk_bit(read_data_valid, 1'b0, "valid early");
    end
    for (int i = 0; i < 4; i++)
    begin
      #(t0 + lat + 40.0 + 62.5 * i - $realtime);
      chk_bit(read_data_valid, 1'b1, "valid");
      chk_bit(dq_oe, 1'b1, "drive");
      chk_word(dq_out, exp[18*i +: 18], "read beat");
    end
    #(t0 + lat + 290.0 - $realtime);
    chk_bit(read_data_valid, post, "valid after");
    chk_bit(dq_oe, post, "drive after");
  endtask

  task automatic read_burst(input logic [5:0] a, input logic [71:0] exp, input real lat);
    dbs_ctrl_model_i.command(1'b1, a);
    check_read(dbs_ctrl_model_i.cmd_t, lat, exp, 1'b0);
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic test_echo();
    @(posedge k);
    #30;
    chk_bit(echo_clock_true, 1'b1, "echo true");
    chk_bit(echo_clock_complement, 1'b0, "echo comp");
    @(posedge k_n);
    #30;
    chk_bit(echo_clock_true, 1'b0, "echo true low");
    chk_bit(echo_clock_complement, 1'b1, "echo comp high");
  endtask

  task automatic test_write_read();
    dbs_ctrl_model_i.write(6'h05, WA, 8'h00);
    read_burst(6'h05, WA, LAT2);
  endtask

  task automatic test_masks();
    dbs_ctrl_model_i.write(6'h05, WN, 8'h36);
    read_burst(6'h05, WM, LAT2);
  endtask

  // Read the address whose write is still in flight, two cycles after the write
  task automatic test_coherent();
    fork
      dbs_ctrl_model_i.write(6'h2a, WC, 8'h00);
      begin
        @(dbs_ctrl_model_i.cmd_ev);
        @(posedge k);
        dbs_ctrl_model_i.command(1'b1, 6'h2a);
      end
    join
    check_read(dbs_ctrl_model_i.cmd_t, LAT2, WC, 1'b0);
  endtask

  task automatic test_back_to_back();
    real t0;
    dbs_ctrl_model_i.command(1'b1, 6'h2a);
    t0 = dbs_ctrl_model_i.cmd_t;
    @(posedge k);
    dbs_ctrl_model_i.command(1'b1, 6'h05);
    check_read(t0, LAT2, WC, 1'b1);
    check_read(t0 + 250.0, LAT2, WM, 1'b0);
  endtask

  task automatic test_no_loop();
    @(posedge mclk);
    #1;
    dll_on = 1'b0;
    read_burst(6'h05, WM, LAT1);
    @(posedge mclk);
    #1;
    dll_on = 1'b1;
  endtask

  // Two writes three cycles apart use both write slots and pass the buffer in turn
  task automatic test_write_pair();
    real t0;
    fork
      dbs_ctrl_model_i.write(6'h11, WN, 8'h00);
      begin
        @(dbs_ctrl_model_i.cmd_ev);
        repeat (2) @(posedge k);
        dbs_ctrl_model_i.write(6'h12, WC, 8'h00);
      end
    join
    dbs_ctrl_model_i.command(1'b1, 6'h11);
    t0 = dbs_ctrl_model_i.cmd_t;
    @(posedge k);
    dbs_ctrl_model_i.command(1'b1, 6'h12);
    check_read(t0, LAT2, WN, 1'b1);
    check_read(t0 + 250.0, LAT2, WC, 1'b0);
  endtask

  initial
  begin
    srst = 1'b1;
    dll_on = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    chk_bit(read_data_valid, 1'b0, "reset valid");
    chk_bit(dq_oe, 1'b0, "reset drive");
    srst = 1'b0;
    test_echo();
    test_write_read();
    test_masks();
    test_coherent();
    test_back_to_back();
    test_no_loop();
    test_write_pair();
    chk_bit(write_overflow, 1'b0, "overflow");
    complete_run();
  end
endmodule
